/* core/adc_scan_sequencer.sv */
// Scan sequencer and register port for an 8-channel SAR converter
//
// Operation
// (RULE_01) Resolution selectable, eight or ten bits
// (RULE_02) Any of eight analog channels selectable
// (RULE_03) Start by software, timer or falling edge
// (RULE_04) Single scan: start to end, then halt
// (RULE_05) Continuous scan restarts at start channel
// (RULE_06) Paused scan: one channel per activation
// (RULE_07) Stored result raises interrupt if enabled
// (RULE_08) Interrupt request launches intelligent I/O transfer
// (RULE_09) Conversion takes at least 6.12 us
// (RULE_10) Sampling lasts at least 2.0 us
// (RULE_11) Sample-hold, then one decision per bit
// (RULE_12) Busy from trigger to halt; ignore triggers
//
// The implementer's own choices: the address map and the plain strobed port.
`include "adc_seq_defs.svh"
module adc_scan_sequencer #(
  parameter int NCH = 8,
  parameter int RES_MAX = 10
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic TIMER_TRIG,
  input wire logic EXT_TRIG_N,
  input wire logic CMP_HIGH,
  output logic [2:0] CH_SEL,
  output logic SAMPLE_EN,
  output logic [RES_MAX-1:0] DAC_CODE,
  output logic BUSY,
  output logic IRQ,
  output logic IO_SVC_REQ,
  input wire logic IO_SVC_ACK,
  output logic [15:0] RES_DATA,
  output logic RES_VALID,
  input wire logic RES_READY
);
  import adc_seq_pkg::*;

  localparam int SAMP_CYC = (`T_SAMP_NS * `MCLK_MHZ + 999) / 1000;
  localparam int CONV_CYC = (`T_CONV_NS * `MCLK_MHZ + 999) / 1000;
  localparam int BIT_CYC = (CONV_CYC - SAMP_CYC + RES_MAX - 1) / RES_MAX;
  localparam int CW = 10;

  logic [7:0] ctrl_q;
  logic [7:0] chan_q;
  logic [3:0] stat_q;
  logic [15:0] data_q;
  seq_state_t state_q;
  logic [2:0] cur_ch_q;
  logic [CW-1:0] tmr_q;
  logic [3:0] bit_q;
  logic [RES_MAX-1:0] sar_q;
  logic ext_prev_q;
  logic irq_q;

  scan_mode_t mode;
  trig_src_t tsrc;
  logic res10;
  logic [2:0] ch_start;
  logic [2:0] ch_end;
  logic trig;
  logic sw_start;
  logic clr_flag;
  logic stop_req;
  logic buf_ready;
  logic [12:0] buf_out;
  logic buf_valid;
  logic [15:0] result;
  logic last_ch;

  function automatic logic [2:0] next_ch(input logic [2:0] c,
                                         input logic [2:0] s,
                                         input logic [2:0] e);
    next_ch = (c == e) ? s : 3'(c + 3'h1);
  endfunction

  assign mode = scan_mode_t'(ctrl_q[`F_MODE_LO +: 2]);
  assign tsrc = trig_src_t'(ctrl_q[`F_TRIG_LO +: 2]);
  assign res10 = ctrl_q[`F_RES10]; // RULE_01
  assign ch_start = chan_q[6:4]; // RULE_02
  assign ch_end = chan_q[2:0];
  assign last_ch = (cur_ch_q == ch_end);
  assign sw_start = WR && ADDR == `A_CTRL && WDATA[`F_START];
  assign stop_req = WR && ADDR == `A_CTRL && WDATA[`F_STOP];
  assign clr_flag = WR && ADDR == `A_STAT && WDATA[`F_IRQF];

  // One source at a time; the external pin acts on its falling edge
  always_comb
  begin
    case (tsrc)
      TRIG_SOFT: trig = sw_start; // RULE_03
      TRIG_TIMER: trig = TIMER_TRIG; // RULE_03
      TRIG_EXT: trig = ext_prev_q && !EXT_TRIG_N; // RULE_03
      default: trig = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      ext_prev_q <= 1'b1;
    else
      ext_prev_q <= EXT_TRIG_N;
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ctrl_q <= `CTRL_RST;
      chan_q <= `CHAN_RST;
    end
    else
    begin
      if (WR && ADDR == `A_CTRL)
        ctrl_q <= {1'b0, WDATA[6:1], 1'b0};
      if (WR && ADDR == `A_CHAN)
        chan_q <= {1'b0, WDATA[6:4], 1'b0, WDATA[2:0]};
    end
  end

  // Result word: channel in 12:10, data in 9:0
  assign result = res10 ? {3'h0, cur_ch_q, sar_q}
                        : {3'h0, cur_ch_q, 2'h0, sar_q[RES_MAX-1 -: 8]};

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      state_q <= ST_IDLE;
      cur_ch_q <= 3'h0;
      tmr_q <= '0;
      bit_q <= 4'h0;
      sar_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE, ST_PAUSE:
        begin
          // Triggers only count while idle or paused
          if (trig) // RULE_12
          begin
            state_q <= ST_SAMPLE;
            if (state_q == ST_IDLE)
              cur_ch_q <= ch_start;
            tmr_q <= CW'(SAMP_CYC - 1);
            sar_q <= '0;
          end
          else if (stop_req)
            state_q <= ST_IDLE;
        end
        ST_SAMPLE:
        begin
          if (tmr_q == '0) // RULE_10
          begin
            state_q <= ST_APPROX;
            bit_q <= res10 ? 4'(RES_MAX - 1) : 4'(RES_MAX - 1);
            sar_q <= RES_MAX'(1) << (RES_MAX - 1);
            tmr_q <= CW'(BIT_CYC - 1);
          end
          else
            tmr_q <= tmr_q - CW'(1);
        end
        ST_APPROX:
        begin
          if (tmr_q == '0) // RULE_09
          begin
            // Comparator says input is below trial code: drop the bit
            if (!CMP_HIGH) // RULE_11
              sar_q[bit_q] <= 1'b0;
            if (bit_q != 4'h0)
              sar_q[bit_q - 4'h1] <= 1'b1;
            // 8-bit mode still walks all ten bits so timing is fixed
            if (bit_q == 4'h0)
              state_q <= ST_STORE;
            else
              bit_q <= bit_q - 4'h1;
            tmr_q <= CW'(BIT_CYC - 1);
          end
          else
            tmr_q <= tmr_q - CW'(1);
        end
        ST_STORE:
        begin
          // Stall until the buffer takes the word; nothing is dropped
          if (buf_ready)
          begin
            if (stop_req || (mode == MODE_SINGLE && last_ch)) // RULE_04
              state_q <= ST_IDLE;
            else if (mode == MODE_PAUSE) // RULE_06
              state_q <= ST_PAUSE;
            else
            begin
              state_q <= ST_SAMPLE; // RULE_05
              tmr_q <= CW'(SAMP_CYC - 1);
              sar_q <= '0;
            end
            cur_ch_q <= next_ch(cur_ch_q, ch_start, ch_end); // RULE_06
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  result_buf #(
    .W(13)
  ) u_buf (
    .clk(CLK_SYS),
    .rst(RST),
    .in_valid(state_q == ST_STORE),
    .in_ready(buf_ready),
    .in_data(result[12:0]),
    .out_valid(buf_valid),
    .out_ready(RES_READY || !RES_VALID),
    .out_data(buf_out)
  );

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      RES_VALID <= 1'b0;
      RES_DATA <= 16'h0000;
    end
    else if (RES_READY || !RES_VALID)
    begin
      RES_VALID <= buf_valid;
      RES_DATA <= {3'h0, buf_out};
    end
  end

  // Status: flag set wins over a software clear in the same cycle
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      stat_q <= 4'h0;
      data_q <= 16'h0000;
    end
    else
    begin
      stat_q[`F_BUSY] <= state_q != ST_IDLE && state_q != ST_PAUSE
                         || trig; // RULE_12
      stat_q[`F_PAUSED] <= state_q == ST_PAUSE;
      if (state_q == ST_STORE && buf_ready)
      begin
        data_q <= result;
        stat_q[`F_IRQF] <= 1'b1; // RULE_07
        stat_q[`F_OVR] <= stat_q[`F_IRQF] && !clr_flag;
      end
      else if (clr_flag)
      begin
        stat_q[`F_IRQF] <= 1'b0;
        stat_q[`F_OVR] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      irq_q <= 1'b0;
      IRQ <= 1'b0;
      IO_SVC_REQ <= 1'b0;
    end
    else
    begin
      irq_q <= stat_q[`F_IRQF] && ctrl_q[`F_IEN];
      IRQ <= stat_q[`F_IRQF] && ctrl_q[`F_IEN]; // RULE_07
      // Service request rises with each new interrupt, drops on ack; an ack in the same cycle wins
      if (IO_SVC_ACK)
        IO_SVC_REQ <= 1'b0;
      else if (state_q == ST_STORE && buf_ready && ctrl_q[`F_IEN])
        IO_SVC_REQ <= 1'b1; // RULE_08
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      CH_SEL <= 3'h0;
      SAMPLE_EN <= 1'b0;
      DAC_CODE <= '0;
      BUSY <= 1'b0;
    end
    else
    begin
      CH_SEL <= cur_ch_q; // RULE_02
      SAMPLE_EN <= state_q == ST_SAMPLE; // RULE_11
      DAC_CODE <= sar_q;
      BUSY <= stat_q[`F_BUSY]; // RULE_12
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      RDATA <= 16'h0000;
    else if (RD)
    begin
      case (ADDR)
        `A_CTRL: RDATA <= {8'h00, ctrl_q};
        `A_CHAN: RDATA <= {8'h00, chan_q};
        `A_STAT: RDATA <= {12'h000, stat_q};
        `A_DATA: RDATA <= data_q;
        default: RDATA <= 16'h0000;
      endcase
    end
    else
      RDATA <= 16'h0000;
  end

  logic unused;
  assign unused = irq_q;
endmodule // adc_scan_sequencer

/* core/adc_seq_defs.svh */
// Register map, field positions and timing constants for the ADC sequencer
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

`define A_CTRL 4'h0
`define A_CHAN 4'h4
`define A_STAT 4'h8
`define A_DATA 4'hC

`define F_START 0
`define F_RES10 1
`define F_IEN 2
`define F_MODE_LO 3
`define F_TRIG_LO 5
`define F_STOP 7

`define F_BUSY 0
`define F_IRQF 1
`define F_PAUSED 2
`define F_OVR 3

`define CTRL_RST 8'h00
`define CHAN_RST 8'h70

`define MCLK_MHZ 100
`define T_CONV_NS 6120
`define T_SAMP_NS 2000

`endif

/* core/adc_seq_pkg.sv */
// Types shared by the ADC scan sequencer
package adc_seq_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_CONT = 2'h1,
    MODE_PAUSE = 2'h2
  } scan_mode_t;

  typedef enum logic [1:0] {
    TRIG_SOFT = 2'h0,
    TRIG_TIMER = 2'h1,
    TRIG_EXT = 2'h2
  } trig_src_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SAMPLE = 5'h02,
    ST_APPROX = 5'h04,
    ST_STORE = 5'h08,
    ST_PAUSE = 5'h10
  } seq_state_t;
endpackage

/* core/result_buf.sv */
// Two-entry valid/ready buffer for conversion results
module result_buf #(
  parameter int W = 13
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (cnt_q != 2'h2);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (push)
        wp_q <= ~wp_q;
      if (pop)
        rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wp_q] <= in_data;
  end

  // Read data come from a register: refilled whenever the head moves
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop))
      begin
        out_valid <= push;
        out_data <= in_data;
      end
      else if (pop || !out_valid)
      begin
        out_valid <= 1'b1;
        out_data <= mem_q[pop ? ~rp_q : rp_q];
      end
    end
  end
endmodule // result_buf

/* verification/adc_seq_asserts.sv */
// Port-level assertions for the ADC scan sequencer
module adc_seq_asserts (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [2:0] CH_SEL,
  input wire logic SAMPLE_EN,
  input wire logic BUSY,
  input wire logic IO_SVC_REQ,
  input wire logic IO_SVC_ACK,
  input wire logic [15:0] RES_DATA,
  input wire logic RES_VALID,
  input wire logic RES_READY
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic [9:0] samp_q;
  logic [9:0] conv_q;
  // Conversion age saturates so a long stall cannot wrap it
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      samp_q <= 10'h0;
      conv_q <= 10'h0;
    end
    else
    begin
      samp_q <= SAMPLE_EN ? samp_q + 10'h1 : 10'h0;
      if (SAMPLE_EN && samp_q == 10'h0)
        conv_q <= 10'h1;
      else if (conv_q != 10'h3FF)
        conv_q <= conv_q + 10'h1;
    end
  end
  a_samp_len: assert property ($fell(SAMPLE_EN) |-> samp_q >= 10'hC8)
    else $error("sampling phase too short");
  a_conv_len: assert property ($rose(IO_SVC_REQ) |-> conv_q >= 10'h264)
    else $error("conversion too short");
  a_idle_quiet: assert property (!BUSY |-> !SAMPLE_EN)
    else $error("sampling while not busy");
  a_start_samples: assert property ($rose(BUSY) |-> ##[0:3] SAMPLE_EN)
    else $error("busy without sampling");
  a_chan_steady: assert property (
    SAMPLE_EN && $past(SAMPLE_EN) |-> $stable(CH_SEL))
    else $error("channel moved during sampling");
  a_ack_clears: assert property (IO_SVC_ACK |=> !IO_SVC_REQ)
    else $error("transfer request survived ack");
  a_res_hold: assert property (
    RES_VALID && !RES_READY |=> RES_VALID && $stable(RES_DATA))
    else $error("result lost during stall");
  a_res_fmt: assert property (RES_VALID |-> RES_DATA[15:13] == 3'h0)
    else $error("result upper bits set");
endmodule // adc_seq_asserts

bind adc_scan_sequencer adc_seq_asserts adc_seq_asserts_inst (.CLK_SYS,
  .RST, .CH_SEL, .SAMPLE_EN, .BUSY, .IO_SVC_REQ, .IO_SVC_ACK, .RES_DATA,
  .RES_VALID, .RES_READY);

/* verification/analog_front.sv */
// Analog inputs with sample-and-hold feeding the comparator
module analog_front (
  input wire logic clk,
  input wire logic [2:0] ch_sel,
  input wire logic sample_en,
  input wire logic [9:0] dac_code,
  output logic cmp_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held_q;
  function automatic logic [9:0] level(input logic [2:0] ch);
    return {7'h0, ch} * 10'h83 + 10'h15;
  endfunction
  // Input is tracked only while sampling; later moves cannot leak in
  always_ff @(posedge clk)
  begin
    if (sample_en)
      held_q <= level(ch_sel);
  end
  assign cmp_high = held_q >= dac_code;
endmodule // analog_front

/* verification/testbench.sv */
// Directed bench for the ADC scan sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic TIMER_TRIG = 1'b0;
  logic EXT_TRIG_N = 1'b1;
  logic IO_SVC_ACK = 1'b0;
  logic RES_READY = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0;
  logic [15:0] RDATA, RES_DATA;
  logic [2:0] CH_SEL;
  logic [9:0] DAC_CODE;
  logic CMP_HIGH, SAMPLE_EN, BUSY, IRQ, IO_SVC_REQ, RES_VALID;
  logic [15:0] got[$];
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int svc_n = 0;
  adc_scan_sequencer adc_scan_sequencer_inst (.CLK_SYS, .RST, .ADDR,
    .WDATA, .WR, .RD, .RDATA, .TIMER_TRIG, .EXT_TRIG_N, .CMP_HIGH,
    .CH_SEL, .SAMPLE_EN, .DAC_CODE, .BUSY, .IRQ, .IO_SVC_REQ,
    .IO_SVC_ACK, .RES_DATA, .RES_VALID, .RES_READY);
  analog_front analog_front_inst (.clk(CLK_SYS), .ch_sel(CH_SEL),
    .sample_en(SAMPLE_EN), .dac_code(DAC_CODE), .cmp_high(CMP_HIGH));
  always #5 CLK_SYS = ~CLK_SYS;
  task automatic finish_test();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Transfer engine stand-in: one ack per request
  always @(posedge CLK_SYS)
  begin
    cyc++;
    if (RES_VALID && RES_READY)
      got.push_back(RES_DATA);
    if (IO_SVC_ACK)
      svc_n++;
    IO_SVC_ACK <= IO_SVC_REQ && !IO_SVC_ACK;
    if (cyc == 40000)
    begin
      failures++;
      finish_test();
    end
  end
  function automatic logic [9:0] lvl(input logic [2:0] c);
    return {7'h0, c} * 10'h83 + 10'h15;
  endfunction
  task automatic chk(input logic [15:0] s, e, input string w);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    // Read data stand only in this cycle: look while they are settled
    @(negedge CLK_SYS);
    chk(RDATA & m, e, "rdata");
    @(posedge CLK_SYS);
  endtask
  task automatic res(input logic [2:0] c, input logic [9:0] v);
    int n;
    n = 0;
    while (got.size() == 0 && n < 3000)
    begin
      @(posedge CLK_SYS);
      n++;
    end
    chk(got.size() > 0 ? got.pop_front() : 16'hFFFF, {3'h0, c, v},
      "result");
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (BUSY !== 1'b0 && n < 3000)
    begin
      @(posedge CLK_SYS);
      n++;
    end
    chk({15'h0, BUSY}, 16'h0, "busy");
  endtask
  initial
  begin
    repeat (3) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    rd(4'h0, 16'h0000, 16'hFFFF);
    rd(4'h4, 16'h0070, 16'hFFFF);
    rd(4'h8, 16'h0000, 16'hFFFF);
    wr(4'h2, 16'hFFFF);
    rd(4'h2, 16'h0000, 16'hFFFF);
    $display("test registers done");
    // Receiver stalls so the two-entry buffer fills and refuses
    RES_READY <= 1'b0;
    wr(4'h4, 16'h0003);
    wr(4'h0, 16'h0007);
    wr(4'h0, 16'h0007);
    rd(4'h8, 16'h0001, 16'h0001);
    repeat (3000) @(posedge CLK_SYS);
    chk(16'(got.size()), 16'h0, "stall");
    chk({15'h0, BUSY}, 16'h1, "busy");
    chk({15'h0, IRQ}, 16'h1, "irq");
    RES_READY <= 1'b1;
    for (int c = 0; c < 4; c++)
      res(3'(c), lvl(3'(c)));
    idle();
    chk(16'(svc_n), 16'h4, "svc");
    repeat (800) @(posedge CLK_SYS);
    chk(16'(got.size()), 16'h0, "extra");
    wr(4'h8, 16'h0002);
    @(posedge CLK_SYS);
    chk({15'h0, IRQ}, 16'h0, "irq");
    $display("test single done");
    wr(4'h4, 16'h0055);
    wr(4'h0, 16'h0005);
    res(3'h5, lvl(3'h5) >> 2);
    idle();
    rd(4'hC, {3'h0, 3'h5, lvl(3'h5) >> 2}, 16'hFFFF);
    $display("test narrow done");
    wr(4'h4, 16'h0067);
    wr(4'h0, 16'h002A);
    TIMER_TRIG <= 1'b1;
    @(posedge CLK_SYS);
    TIMER_TRIG <= 1'b0;
    for (int i = 0; i < 3; i++)
      res(3'(6 + i % 2), lvl(3'(6 + i % 2)));
    wr(4'h0, 16'h0080);
    idle();
    repeat (5) @(posedge CLK_SYS);
    got.delete();
    $display("test continuous done");
    wr(4'h4, 16'h0001);
    wr(4'h0, 16'h0052);
    for (int i = 0; i < 3; i++)
    begin
      EXT_TRIG_N <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      EXT_TRIG_N <= 1'b1;
      res(3'(i % 2), lvl(3'(i % 2)));
      idle();
      rd(4'h8, 16'h0004, 16'h0004);
    end
    $display("test paused done");
    finish_test();
  end
endmodule // testbench
